// file: design/rdc_pkg.sv
// Constants for the recombiner delay control register bank.
// Assumes a 16-bit microprocessor register port on the device core clock.
package rdc_pkg;
   localparam logic [11:0] ADDR_SRAM_CTRL = 12'h280;
   localparam logic [11:0] ADDR_INC_REQ = 12'h281;
   localparam logic [11:0] ADDR_DEC_REQ = 12'h282;
   localparam logic [11:0] ADDR_WAIT_CELL = 12'h283;
   localparam logic [11:0] ADDR_SRAM_DATA = 12'h284;
   localparam logic [11:0] ADDR_DELAY_RB = 12'h285;
   localparam logic [11:0] ADDR_SRAM_ADDR_HI = 12'h297;
   localparam logic [11:0] ADDR_SRAM_ADDR_LO = 12'h298;
   localparam int NUM_GROUPS = 8;
   localparam int NUM_LINKS = 16;
   localparam int CTRL_READY_BIT = 7;
   localparam int CTRL_TOGGLE_BIT = 6;
   localparam int CTRL_DIR_BIT = 5;
   localparam logic [15:0] CTRL_WR_MASK = 16'h0027;
   localparam logic [15:0] CTRL_RESET = 16'h0080;
   localparam logic [10:0] DELAY_RESET = 11'h004;
   localparam int DELAY_SIGN_BIT = 10;
   localparam int ADJ_WIDTH = 14;
   typedef enum logic [1:0] {ADJ_IDLE, ADJ_BUSY} rdc_adj_type;
   typedef enum logic [1:0] {XFR_IDLE, XFR_RUN} rdc_xfr_type;
endpackage

// file: design/rdc_regs.sv
// Recombiner delay control register bank: adjust requests, link wait enables,
// external SRAM data/control/address and signed delay readback.
// Assumes recombiner core and SRAM controller on clk; inputs are synchronous.
// Only one adjustment is in flight; the recombiner answers each with adj_done.
module rdc_regs (
   input wire logic clk, // Core clock, 200 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [11:0] reg_addr, // Register address
   input wire logic reg_wr, // Write strobe, one cycle
   input wire logic reg_rd, // Read strobe, one cycle
   input wire logic [15:0] reg_wdata, // Write data
   output logic [15:0] reg_rdata_q, // Read data, valid cycle after reg_rd
   input wire logic [13:0] delta_delay, // Guardband/delta step setting
   output logic adj_valid_q, // Adjustment request pulse to recombiner
   output logic [2:0] adj_group_q, // Group being adjusted
   output logic adj_dir_dec_q, // 1 decrease, 0 increase
   output logic [13:0] adj_amount_q, // Step size captured at apply time
   input wire logic adj_done, // Recombiner finished adjustment
   output logic [15:0] link_wait_q, // Per-link wait for first user cell
   input wire logic [10:0] sel_delay, // Selected delay incl. guardband
   output logic sram_start_q, // Transfer start pulse
   output logic sram_load_q, // 1 load from RAM, 0 store to RAM
   output logic [1:0] sram_mode_q, // Control bits 1:0
   output logic [19:0] sram_addr_q, // 20-bit transfer address
   output logic [7:0] sram_wdata_q, // Data to external RAM
   input wire logic [7:0] sram_rdata, // Data from external RAM
   input wire logic sram_rvalid, // Read data capture strobe
   input wire logic sram_done // Transfer completed
);
   logic [7:0] inc_q;
   logic [7:0] dec_q;
   logic [15:0] ctrl_q;
   logic [15:0] delay_q;
   rdc_pkg::rdc_adj_type adj_state_q;
   rdc_pkg::rdc_xfr_type xfr_q;
   logic [2:0] scan_q;
   logic wr_inc;
   logic wr_dec;
   logic wr_ctrl;
   logic wr_wait;
   logic wr_data;
   logic wr_addr_hi;
   logic wr_addr_lo;
   logic [7:0] inc_clr;
   logic [7:0] dec_clr;

   // Strobe qualified by one register address
   function automatic logic reg_hit(input logic strobe, input logic [11:0] addr,
         input logic [11:0] target);
      return strobe && addr == target;
   endfunction

   assign wr_inc = reg_hit(reg_wr, reg_addr, rdc_pkg::ADDR_INC_REQ);
   assign wr_dec = reg_hit(reg_wr, reg_addr, rdc_pkg::ADDR_DEC_REQ);
   assign wr_ctrl = reg_hit(reg_wr, reg_addr, rdc_pkg::ADDR_SRAM_CTRL);
   assign wr_wait = reg_hit(reg_wr, reg_addr, rdc_pkg::ADDR_WAIT_CELL);
   assign wr_data = reg_hit(reg_wr, reg_addr, rdc_pkg::ADDR_SRAM_DATA);
   assign wr_addr_hi = reg_hit(reg_wr, reg_addr, rdc_pkg::ADDR_SRAM_ADDR_HI);
   assign wr_addr_lo = reg_hit(reg_wr, reg_addr, rdc_pkg::ADDR_SRAM_ADDR_LO);

   // Clear pulse for the bit whose adjustment just completed
   always_comb begin
      inc_clr = 8'h00;
      dec_clr = 8'h00;
      if (adj_state_q == rdc_pkg::ADJ_BUSY && adj_done) begin
         if (adj_dir_dec_q) begin
            dec_clr[adj_group_q] = 1'b1;
         end else begin
            inc_clr[adj_group_q] = 1'b1;
         end
      end
   end

   // Writing 1 sets, 0 leaves; set wins over hardware clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inc_q <= 8'h00;
         dec_q <= 8'h00;
      end else begin
         inc_q <= (inc_q & ~inc_clr) | (wr_inc ? reg_wdata[7:0] : 8'h00);
         dec_q <= (dec_q & ~dec_clr) | (wr_dec ? reg_wdata[7:0] : 8'h00);
      end
   end

   // Round-robin scheduler, one adjustment at a time, increase first
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         adj_state_q <= rdc_pkg::ADJ_IDLE;
         scan_q <= 3'h0;
         adj_valid_q <= 1'b0;
         adj_group_q <= 3'h0;
         adj_dir_dec_q <= 1'b0;
         adj_amount_q <= 14'h0000;
      end else begin
         adj_valid_q <= 1'b0;
         case (adj_state_q)
            rdc_pkg::ADJ_IDLE: begin
               // Scan pointer parks on a group until all its requests are served
               if (inc_q[scan_q] || dec_q[scan_q]) begin
                  adj_state_q <= rdc_pkg::ADJ_BUSY;
                  adj_valid_q <= 1'b1;
                  adj_group_q <= scan_q;
                  adj_dir_dec_q <= ~inc_q[scan_q];
                  adj_amount_q <= delta_delay;
               end else begin
                  scan_q <= scan_q + 3'h1;
               end
            end
            rdc_pkg::ADJ_BUSY: begin
               if (adj_done) begin
                  adj_state_q <= rdc_pkg::ADJ_IDLE;
               end
            end
            default: begin
               adj_state_q <= rdc_pkg::ADJ_IDLE;
            end
         endcase
      end
   end

   // Link wait-for-first-cell enables; a clear bit joins immediately
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link_wait_q <= 16'h0000;
      end else if (wr_wait) begin
         link_wait_q <= reg_wdata;
      end
   end

   // Transfer sequencer: runs from a control write until the RAM side is done
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xfr_q <= rdc_pkg::XFR_IDLE;
      end else begin
         case (xfr_q)
            rdc_pkg::XFR_IDLE: begin
               if (wr_ctrl) begin
                  xfr_q <= rdc_pkg::XFR_RUN;
               end
            end
            rdc_pkg::XFR_RUN: begin
               // A write in the same cycle starts a new transfer and keeps ready low
               if (sram_done && !wr_ctrl) begin
                  xfr_q <= rdc_pkg::XFR_IDLE;
               end
            end
            default: begin
               xfr_q <= rdc_pkg::XFR_IDLE;
            end
         endcase
      end
   end

   // External SRAM control, ready and toggle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= rdc_pkg::CTRL_RESET;
         sram_start_q <= 1'b0;
      end else begin
         sram_start_q <= wr_ctrl;
         if (wr_ctrl) begin
            ctrl_q[5:0] <= reg_wdata[5:0] & rdc_pkg::CTRL_WR_MASK[5:0];
            ctrl_q[rdc_pkg::CTRL_READY_BIT] <= 1'b0;
         end else if (sram_done && xfr_q == rdc_pkg::XFR_RUN) begin
            ctrl_q[rdc_pkg::CTRL_READY_BIT] <= 1'b1;
            ctrl_q[rdc_pkg::CTRL_TOGGLE_BIT] <= ~ctrl_q[rdc_pkg::CTRL_TOGGLE_BIT];
         end
      end
   end
   // Direction and mode are wired straight from the control flops
   assign sram_load_q = ctrl_q[rdc_pkg::CTRL_DIR_BIT];
   assign sram_mode_q = ctrl_q[1:0];

   // Address and data registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sram_addr_q <= 20'h00000;
         sram_wdata_q <= 8'h00;
      end else begin
         if (wr_addr_hi) begin
            sram_addr_q[19:16] <= reg_wdata[3:0];
         end
         if (wr_addr_lo) begin
            sram_addr_q[15:0] <= reg_wdata;
         end
         // RAM read data wins over a bus write in the same cycle
         if (sram_rvalid) begin
            sram_wdata_q <= sram_rdata;
         end else if (wr_data) begin
            sram_wdata_q <= reg_wdata[7:0];
         end
      end
   end

   // Signed delay readback
   // Bit 10 is copied upward so a negative delay reads as a 16-bit negative
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         delay_q <= {{5{1'b0}}, rdc_pkg::DELAY_RESET};
      end else begin
         delay_q <= {{5{sel_delay[rdc_pkg::DELAY_SIGN_BIT]}}, sel_delay};
      end
   end

   // Read mux; unused bits and unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            rdc_pkg::ADDR_SRAM_CTRL: reg_rdata_q <= ctrl_q;
            rdc_pkg::ADDR_INC_REQ: reg_rdata_q <= {8'h00, inc_q};
            rdc_pkg::ADDR_DEC_REQ: reg_rdata_q <= {8'h00, dec_q};
            rdc_pkg::ADDR_WAIT_CELL: reg_rdata_q <= link_wait_q;
            rdc_pkg::ADDR_SRAM_DATA: reg_rdata_q <= {8'h00, sram_wdata_q};
            rdc_pkg::ADDR_DELAY_RB: reg_rdata_q <= delay_q;
            rdc_pkg::ADDR_SRAM_ADDR_HI: reg_rdata_q <= {12'h000, sram_addr_q[19:16]};
            rdc_pkg::ADDR_SRAM_ADDR_LO: reg_rdata_q <= sram_addr_q[15:0];
            default: reg_rdata_q <= 16'h0000;
         endcase
      end
   end
endmodule

// file: verification/rdc_regs_sva.sv
// Checker for the recombiner delay control register bank.
// Assumes single-cycle bus strobes on clk; bound to rdc_regs below.
module rdc_regs_sva (
   input wire logic clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [11:0] reg_addr, // Address
   input wire logic reg_wr, // Write
   input wire logic reg_rd, // Read
   input wire logic [15:0] reg_wdata, // Wdata
   input wire logic [15:0] reg_rdata_q, // Rdata
   input wire logic [13:0] delta_delay, // Step
   input wire logic adj_valid_q, // Start
   input wire logic [2:0] adj_group_q, // Group
   input wire logic [13:0] adj_amount_q, // Amount
   input wire logic adj_done, // Done
   input wire logic [15:0] link_wait_q, // Waits
   input wire logic sram_start_q, // Xfer
   input wire logic sram_load_q // Dir
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic pend_q;
   // Set by each adjustment start, cleared by its completion
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pend_q <= 1'b0;
      end else if (adj_valid_q) begin
         pend_q <= 1'b1;
      end else if (adj_done) begin
         pend_q <= 1'b0;
      end
   end
   sequence s_ctrl_wr;
      reg_wr && reg_addr == 12'h280;
   endsequence
   sequence s_rd(logic [11:0] a);
      reg_rd && reg_addr == a;
   endsequence
   a_ctrl_starts: assert property (s_ctrl_wr |=> sram_start_q)
      else $error("no start after control write");
   a_start_cause: assert property (sram_start_q |-> $past(reg_wr && reg_addr == 12'h280))
      else $error("start without control write");
   a_dir_follows: assert property (s_ctrl_wr |=> sram_load_q == $past(reg_wdata[5]))
      else $error("direction wrong");
   a_wait_written: assert property (reg_wr && reg_addr == 12'h283
      |=> link_wait_q == $past(reg_wdata)) else $error("wait enables wrong");
   a_amount_taken: assert property (adj_valid_q |-> adj_amount_q == $past(delta_delay))
      else $error("step size wrong");
   a_one_pending: assert property (adj_valid_q |-> !pend_q)
      else $error("second adjustment started");
   a_amount_stable: assert property (!adj_valid_q |-> $stable({adj_group_q, adj_amount_q}))
      else $error("group or step changed without a start");
   a_sign_copy: assert property (s_rd(12'h285)
      |=> reg_rdata_q[15:11] == {5{reg_rdata_q[10]}}) else $error("sign bits wrong");
   a_upper_zero: assert property (reg_rd && (reg_addr == 12'h281 || reg_addr == 12'h282
      || reg_addr == 12'h284) |=> reg_rdata_q[15:8] == 8'h00) else $error("upper bits set");
endmodule
bind rdc_regs rdc_regs_sva u_sva (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
   .reg_rdata_q, .delta_delay, .adj_valid_q, .adj_group_q, .adj_amount_q, .adj_done,
   .link_wait_q, .sram_start_q, .sram_load_q);

// file: verification/tb.sv
// Self-checking bench for the recombiner delay control register bank.
// Drives the register port and recombiner/SRAM handshakes directly.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, adj_done = 0;
   logic sram_rvalid = 0, sram_done = 0, adj_valid_q, adj_dir_dec_q, sram_start_q, sram_load_q;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, link_wait_q;
   logic [13:0] delta_delay = 14'h1A5, adj_amount_q, cap_amt;
   logic [10:0] sel_delay = 11'h004;
   logic [7:0] sram_rdata = 8'hC3, sram_wdata_q;
   logic [19:0] sram_addr_q;
   logic [2:0] adj_group_q, cap_grp;
   logic [1:0] sram_mode_q;
   logic cap_dir;
   int bad_count = 0, n_tests = 0, n_adj = 0, cyc = 0;
   rdc_regs uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .delta_delay(delta_delay), .adj_valid_q(adj_valid_q), .adj_group_q(adj_group_q),
      .adj_dir_dec_q(adj_dir_dec_q), .adj_amount_q(adj_amount_q), .adj_done(adj_done),
      .link_wait_q(link_wait_q), .sel_delay(sel_delay), .sram_start_q(sram_start_q),
      .sram_load_q(sram_load_q), .sram_mode_q(sram_mode_q), .sram_addr_q(sram_addr_q),
      .sram_wdata_q(sram_wdata_q), .sram_rdata(sram_rdata), .sram_rvalid(sram_rvalid),
      .sram_done(sram_done));
   initial forever #2.5 clk = ~clk;
   // Latch each adjustment start so a pulse during a bus cycle is not missed
   always @(posedge clk) begin
      cyc++;
      if (adj_valid_q === 1'b1) begin
         n_adj++;
         {cap_dir, cap_grp, cap_amt} = {adj_dir_dec_q, adj_group_q, adj_amount_q};
      end
      if (cyc > 3000) begin
         bad_count++;
         report_and_stop;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk) #1;
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(posedge clk) #1;
      reg_wr = 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      @(posedge clk) #1;
      {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge clk) #1;
      reg_rd = 0;
      @(posedge clk) #1;
      check(reg_rdata_q, exp);
   endtask
   task automatic wait_adj(input int n);
      while (n_adj < n) @(posedge clk) #1;
   endtask
   task automatic pulse_adj;
      @(posedge clk) #1;
      adj_done = 1;
      @(posedge clk) #1;
      adj_done = 0;
   endtask
   task automatic pulse_done;
      @(posedge clk) #1;
      sram_done = 1;
      @(posedge clk) #1;
      sram_done = 0;
   endtask
   task automatic t_reset;
      rd(12'h280, 16'h0080);
      for (int i = 1; i < 5; i++) rd(12'h280 + 12'(i), 16'h0000);
      rd(12'h285, 16'h0004);
   endtask
   task automatic t_adjust;
      wr(12'h281, 16'hFF01);
      wr(12'h281, 16'h0000);
      wr(12'h282, 16'h0001);
      rd(12'h281, 16'h0001);
      wait_adj(1);
      check({12'h000, cap_dir, cap_grp}, 16'h0000);
      check({2'b00, cap_amt}, 16'h01A5);
      delta_delay = 14'h2C3;
      pulse_adj;
      rd(12'h281, 16'h0000);
      rd(12'h282, 16'h0001);
      wait_adj(2);
      check({12'h000, cap_dir, cap_grp}, 16'h0008);
      check({2'b00, cap_amt}, 16'h02C3);
      pulse_adj;
      rd(12'h282, 16'h0000);
      wr(12'h281, 16'h0008);
      wait_adj(3);
      check({12'h000, cap_dir, cap_grp}, 16'h0003);
      pulse_adj;
      rd(12'h281, 16'h0000);
   endtask
   task automatic t_sram;
      wr(12'h283, 16'hA5C2);
      check(link_wait_q, 16'hA5C2);
      rd(12'h283, 16'hA5C2);
      wr(12'h297, 16'hFFF5);
      wr(12'h298, 16'h1234);
      rd(12'h297, 16'h0005);
      wr(12'h284, 16'hAB5A);
      rd(12'h284, 16'h005A);
      check({sram_addr_q[19:16], sram_wdata_q, 4'h0}, 16'h55A0);
      check(sram_addr_q[15:0], 16'h1234);
      wr(12'h280, 16'h0021);
      check({12'h000, sram_start_q, sram_load_q, sram_mode_q}, 16'h000D);
      rd(12'h280, 16'h0021);
      sram_rvalid = 1;
      @(posedge clk) #1;
      sram_rvalid = 0;
      pulse_done;
      rd(12'h280, 16'h00E1);
      rd(12'h284, 16'h00C3);
      wr(12'h280, 16'hFFD9);
      check({12'h000, sram_start_q, sram_load_q, sram_mode_q}, 16'h0009);
      rd(12'h280, 16'h0041);
      pulse_done;
      rd(12'h280, 16'h0081);
      pulse_done;
      rd(12'h280, 16'h0081);
      rd(12'h2A0, 16'h0000);
      sel_delay = 11'h7F0;
      rd(12'h285, 16'hFFF0);
      sel_delay = 11'h3F0;
      wr(12'h285, 16'h1234);
      rd(12'h285, 16'h03F0);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1;
      sys_rst = 0;
      t_reset;
      t_adjust;
      t_sram;
      report_and_stop;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
endmodule
